// *** rtl/addr_space_params.svh ***
// Purpose: Constants for the address space decoder
// Assumes: Byte-wide register file and program memory
// Notes:   Addresses in hex, sizes in bytes
`ifndef ADDR_SPACE_PARAMS_SVH
`define ADDR_SPACE_PARAMS_SVH

`define RF_SIZE          4096
`define RF_CTRL_BASE     12'hF00
`define RF_RAM_BASE      12'h000
`define RF_RAM_BYTES     1024
`define PM_FLASH_BYTES   8192
`define PM_UNIMPL_DATA   8'hFF
`define INFO_BASE        16'hFE00
`define INFO_BYTES       512
`define INFO_ENABLE_BIT  7
`define PART_ID_BASE     9'h040
`define PART_ID_LEN      20
`define RESERVED_DATA    8'h00

`endif

// *** rtl/addr_space_pkg.sv ***
// Purpose: Types shared by the address space decoder
// Assumes: One access per cycle from the CPU core
// Notes:   Requests and answers travel as packed structs
package addr_space_pkg;

  typedef enum logic [1:0] {
    SPACE_REG,
    SPACE_PROG,
    SPACE_DATA,
    SPACE_NONE
  } space_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    space_t      space;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
  } cpu_rsp_t;

  typedef enum logic [2:0] {
    REGION_RAM,
    REGION_CTRL,
    REGION_RF_HOLE,
    REGION_FLASH,
    REGION_PM_HOLE,
    REGION_INFO,
    REGION_DATA
  } region_t;

endpackage

// *** rtl/info_area_rom.sv ***
// Purpose: Read-only information area with the part identifier
// Assumes: Part identifier given as a parameter string
// Notes:   Contents are constant; there is no write port at all
`timescale 1ns/1ps
`include "addr_space_params.svh"

module info_area_rom #(
  parameter logic [8*`PART_ID_LEN-1:0] PART_ID = "EXAMPLE-PART"  // Arbitrary value
) (
  // Lookup
  input  wire logic [8:0] offset_i,
  output logic      [7:0] data_o
);

  // A short string literal lands right-justified in the parameter, so count its leading zero bytes
  function automatic int lead_pad(input logic [8*`PART_ID_LEN-1:0] v);
    int n;
    n = 0;
    for (int k = `PART_ID_LEN - 1; k >= 0; k--) begin
      if (v[8*k +: 8] != 8'h00) begin
        break;
      end
      n++;
    end
    return n;
  endfunction

  localparam int PAD = lead_pad(PART_ID);

  logic [7:0] id_bytes [`PART_ID_LEN];

  // Left-justified characters, zero padding after the string ends
  genvar g;
  generate
    for (g = 0; g < `PART_ID_LEN; g++) begin : g_id
      if (g < `PART_ID_LEN - PAD) begin : g_chr
        assign id_bytes[g] = PART_ID[8*(`PART_ID_LEN-1-g-PAD) +: 8];
      end else begin : g_pad
        assign id_bytes[g] = 8'h00;
      end
    end
  endgenerate

  // Identifier field or reserved content elsewhere
  always_comb begin
    logic [8:0] idx;
    idx    = offset_i - `PART_ID_BASE;
    data_o = `RESERVED_DATA;
    if (offset_i >= `PART_ID_BASE && idx < 9'(`PART_ID_LEN)) begin
      data_o = id_bytes[idx[4:0]];
    end
  end

endmodule

// *** rtl/addr_space_decoder.sv ***
// Purpose: Address decoding of register file, program memory and data space
// Assumes: One request per cycle; read data one cycle later
// Notes:   Control window is forwarded to peripherals outside
//
// Contract
// - Register file spans 4096 bytes, control and general-purpose sections.
// - Addresses F00H to FFFH form the control-register window.
// - Reserved control locations may read back any value.
// - On-chip RAM of 1KB starts at register address 000H.
// - Holes between RAM and control window read undefined, writes ignored.
// - Source registers are read, destination registers are written.
// - Any general-purpose register serves any purpose, no location restriction.
// - 64KB program space holds 4KB or 8KB flash per variant.
// - Program reads beyond flash return FFH.
// - Program writes to unimplemented addresses change nothing.
// - Data memory space has no storage mapped.
// - Page select bit 7 set enables information area access.
// - Enabled information area overlays FE00H through FFFFH.
// - Overlay reads return information area instead of flash.
// - Information area is read-only; writes change nothing.
// - Part identifier of 20 ASCII bytes at FE40H, zero padded.
`timescale 1ns/1ps
`include "addr_space_params.svh"

module addr_space_decoder #(
  parameter int FLASH_BYTES = `PM_FLASH_BYTES,
  parameter int RAM_BYTES   = `RF_RAM_BYTES
) (
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      resetn_i,
  // CPU access
  input  wire addr_space_pkg::cpu_req_t  req_i,
  output addr_space_pkg::cpu_rsp_t       rsp_o,
  // Page select bit 7 from the CPU
  input  wire logic [7:0]                page_select_i,
  // Control window towards the peripherals
  output logic                           ctrl_rd_o,
  output logic                           ctrl_wr_o,
  output logic      [7:0]                ctrl_addr_o,
  output logic      [7:0]                ctrl_wdata_o,
  input  wire logic [7:0]                ctrl_rdata_i,
  // Flash write path for programming logic outside
  output logic                           flash_wr_o,
  output logic      [15:0]               flash_addr_o,
  output logic      [7:0]                flash_wdata_o
);

  localparam int RF_AW = $clog2(`RF_SIZE);
  localparam int RAM_AW = $clog2(RAM_BYTES);
  localparam int FL_AW = $clog2(FLASH_BYTES);

  // Storage
  logic [7:0] ram_mem   [RAM_BYTES];
  logic [7:0] flash_mem [FLASH_BYTES];

  // Decode state
  addr_space_pkg::region_t region_r, region_nxt;
  logic                    rd_pend_r, rd_pend_nxt;
  logic [15:0]             addr_r, addr_nxt;
  logic [7:0]              ram_q_r;
  logic [7:0]              flash_q_r;
  logic [7:0]              info_q;
  logic [RF_AW-1:0]        rf_addr;
  logic                    info_en;

  assign rf_addr = req_i.addr[RF_AW-1:0];
  assign info_en = page_select_i[`INFO_ENABLE_BIT];

  // Region decode for the current request
  always_comb begin
    region_nxt = addr_space_pkg::REGION_DATA;
    case (req_i.space)
      addr_space_pkg::SPACE_REG: begin
        if (rf_addr >= RF_AW'(`RF_CTRL_BASE)) begin
          region_nxt = addr_space_pkg::REGION_CTRL;
        end else if (rf_addr < RF_AW'(`RF_RAM_BASE + RAM_BYTES)) begin
          region_nxt = addr_space_pkg::REGION_RAM;
        end else begin
          region_nxt = addr_space_pkg::REGION_RF_HOLE;
        end
      end
      addr_space_pkg::SPACE_PROG: begin
        if (info_en && req_i.addr >= `INFO_BASE) begin
          region_nxt = addr_space_pkg::REGION_INFO;
        end else if (req_i.addr < 16'(FLASH_BYTES)) begin
          region_nxt = addr_space_pkg::REGION_FLASH;
        end else begin
          region_nxt = addr_space_pkg::REGION_PM_HOLE;
        end
      end
      addr_space_pkg::SPACE_DATA: begin
        region_nxt = addr_space_pkg::REGION_DATA;
      end
      default: begin
        region_nxt = addr_space_pkg::REGION_DATA;
      end
    endcase
    rd_pend_nxt = req_i.valid && !req_i.write;
    addr_nxt    = req_i.addr;
  end

  // Register the decode so the answer lines up with the memory read
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      region_r  <= addr_space_pkg::REGION_DATA;
      rd_pend_r <= 1'b0;
      addr_r    <= 16'h0000;
    end else begin
      region_r  <= region_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r    <= addr_nxt;
    end
  end

  // RAM: no reset so it maps to block memory; contents start undefined
  always_ff @(posedge ref_clk_i) begin
    if (req_i.valid && req_i.write && region_nxt == addr_space_pkg::REGION_RAM) begin
      ram_mem[rf_addr[RAM_AW-1:0]] <= req_i.wdata;
    end
    ram_q_r <= ram_mem[rf_addr[RAM_AW-1:0]];
  end

  // Flash read port; writes go out to the programming logic instead
  always_ff @(posedge ref_clk_i) begin
    flash_q_r <= flash_mem[req_i.addr[FL_AW-1:0]];
  end

  // Flash array is loaded by programming logic not modelled here
  initial begin
    for (int i = 0; i < FLASH_BYTES; i++) begin
      flash_mem[i] = `PM_UNIMPL_DATA;
    end
  end

  // Information area overlay
  info_area_rom u_info (
    .offset_i (addr_r[8:0]),
    .data_o   (info_q)
  );

  // Control window strobes; reserved locations are not filtered here
  always_comb begin
    ctrl_rd_o    = req_i.valid && !req_i.write && region_nxt == addr_space_pkg::REGION_CTRL;
    ctrl_wr_o    = req_i.valid && req_i.write && region_nxt == addr_space_pkg::REGION_CTRL;
    ctrl_addr_o  = rf_addr[7:0];
    ctrl_wdata_o = req_i.wdata;
  end

  // Flash writes only inside the flash; holes and the overlay drop them
  always_comb begin
    flash_wr_o    = req_i.valid && req_i.write && region_nxt == addr_space_pkg::REGION_FLASH;
    flash_addr_o  = req_i.addr;
    flash_wdata_o = req_i.wdata;
  end

  // Read answer select, one cycle after the request
  always_comb begin
    rsp_o.valid = rd_pend_r;
    rsp_o.rdata = `RESERVED_DATA;
    case (region_r)
      addr_space_pkg::REGION_RAM:     rsp_o.rdata = ram_q_r;
      addr_space_pkg::REGION_CTRL:    rsp_o.rdata = ctrl_rdata_i;
      addr_space_pkg::REGION_RF_HOLE: rsp_o.rdata = `RESERVED_DATA;
      addr_space_pkg::REGION_FLASH:   rsp_o.rdata = flash_q_r;
      addr_space_pkg::REGION_PM_HOLE: rsp_o.rdata = `PM_UNIMPL_DATA;
      addr_space_pkg::REGION_INFO:    rsp_o.rdata = info_q;
      addr_space_pkg::REGION_DATA:    rsp_o.rdata = `RESERVED_DATA;
      default:                        rsp_o.rdata = `RESERVED_DATA;
    endcase
  end

endmodule

// *** sim/addr_space_chk.sv ***
// Purpose: Port checker for the address space decoder
// Assumes: Port types as the top module declares them
// Notes:   Register file hole and data space reads are held to the chosen 00, program holes to FF
`timescale 1ns/1ps
module addr_space_chk #(
  parameter int FLASH_BYTES = 8192
) (
  // Clock, reset and request
  input wire logic                     ref_clk_i,
  input wire logic                     resetn_i,
  input wire addr_space_pkg::cpu_req_t req_i,
  input wire logic [7:0]               page_select_i,
  // Answers and strobes
  input wire addr_space_pkg::cpu_rsp_t rsp_o,
  input wire logic                     ctrl_rd_o,
  input wire logic                     ctrl_wr_o,
  input wire logic [7:0]               ctrl_rdata_i,
  input wire logic                     flash_wr_o,
  input wire logic [15:0]              flash_addr_o,
  input wire logic [7:0]               flash_wdata_o,
  input wire logic [7:0]               ctrl_addr_o,
  input wire logic [7:0]               ctrl_wdata_o
);
  // Decoded views of the request, address bits above 11 ignored in register space
  wire logic rd   = req_i.valid && !req_i.write;
  wire logic wr   = req_i.valid && req_i.write;
  wire logic rsp  = req_i.space == addr_space_pkg::SPACE_REG;
  wire logic prg  = req_i.space == addr_space_pkg::SPACE_PROG;
  wire logic ovl  = page_select_i[7] && req_i.addr >= 16'hFE00;
  wire logic ctl  = rsp && req_i.addr[11:8] == 4'hF;
  wire logic hole = rsp && req_i.addr[11:0] >= 12'h400 && !ctl;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_read_answer: assert property (rd |=> rsp_o.valid) else $error("read not answered");
  a_write_silent: assert property (!rd |=> !rsp_o.valid) else $error("answer without read");
  a_ctrl_rd: assert property (ctrl_rd_o == (rd && ctl)) else $error("ctrl read strobe wrong");
  a_ctrl_wr: assert property (ctrl_wr_o == (wr && ctl)) else $error("ctrl write strobe wrong");
  a_ctrl_data: assert property (rd && ctl |=> rsp_o.rdata == ctrl_rdata_i) else $error("ctrl data lost");
  a_rf_hole: assert property (rd && hole |=> rsp_o.rdata == 8'h00) else $error("hole read wrong");
  a_flash_hole: assert property (rd && prg && !ovl && req_i.addr >= FLASH_BYTES |=> rsp_o.rdata == 8'hFF)
    else $error("flash hole not FF");
  a_flash_wr: assert property (flash_wr_o == (wr && prg && !ovl && req_i.addr < FLASH_BYTES))
    else $error("flash write gate wrong");
  a_data_none: assert property (rd && req_i.space == addr_space_pkg::SPACE_DATA |=> rsp_o.rdata == 8'h00)
    else $error("data space read wrong");
  a_flash_pass: assert property (flash_wr_o |-> flash_addr_o == req_i.addr && flash_wdata_o == req_i.wdata)
    else $error("flash write path wrong");
  a_ctrl_pass: assert property (ctrl_wr_o |-> ctrl_addr_o == req_i.addr[7:0] && ctrl_wdata_o == req_i.wdata)
    else $error("ctrl write path wrong");
  c_ctrl: cover property (rd && ctl);
  c_info: cover property (rd && prg && ovl);
  c_flash: cover property (flash_wr_o);
endmodule

// *** sim/periph_model.sv ***
// Purpose: Peripheral side of the control window
// Assumes: Read data is sampled in the cycle after the strobe
// Notes:   Outside answers the bus shows the inverse of its last value
`timescale 1ns/1ps
module periph_model (
  // Strobe side
  input wire logic       ref_clk_i,
  input wire logic       ctrl_rd_o,
  input wire logic [7:0] ctrl_addr_o,
  // Answer
  output logic     [7:0] ctrl_rdata_i
);
  // Scrambled when idle so a stale byte never passes for an answer
  always_ff @(posedge ref_clk_i) begin
    ctrl_rdata_i <= ctrl_rd_o ? ctrl_addr_o ^ 8'hA5 : ~ctrl_rdata_i;
  end
endmodule

// *** sim/test_addr_space_decoder.sv ***
// Purpose: Self-checking bench of the address space decoder
// Assumes: Small flash variant of 4096 bytes
// Notes:   Driver notes expected read bytes, monitor compares
`timescale 1ns/1ps
module test_addr_space_decoder;
  // Stimulus and observation
  logic                     ref_clk_i;
  logic                     resetn_i;
  addr_space_pkg::cpu_req_t req_i;
  addr_space_pkg::cpu_rsp_t rsp_o;
  logic [7:0]               page_select_i;
  logic                     ctrl_rd_o;
  logic [7:0]               ctrl_addr_o;
  logic [7:0]               ctrl_rdata_i;
  logic [7:0]               exp_q[$];
  logic [7:0]               d0, d, e;
  int                       err_total, checked;
  string                    id = "EXAMPLE-PART";
  localparam addr_space_pkg::space_t sr = addr_space_pkg::SPACE_REG;
  localparam addr_space_pkg::space_t sp = addr_space_pkg::SPACE_PROG;
  localparam addr_space_pkg::space_t sd = addr_space_pkg::SPACE_DATA;
  addr_space_decoder #(.FLASH_BYTES(4096)) i_addr_space_decoder (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .req_i(req_i), .rsp_o(rsp_o), .page_select_i(page_select_i), .ctrl_rd_o(ctrl_rd_o), .ctrl_wr_o(),
    .ctrl_addr_o(ctrl_addr_o), .ctrl_wdata_o(), .ctrl_rdata_i(ctrl_rdata_i), .flash_wr_o(),
    .flash_addr_o(), .flash_wdata_o());
  periph_model i_periph_model (.ref_clk_i(ref_clk_i), .ctrl_rd_o(ctrl_rd_o), .ctrl_addr_o(ctrl_addr_o),
    .ctrl_rdata_i(ctrl_rdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  // One request per cycle, held valid so back-to-back requests follow
  task automatic acc(input logic w, input addr_space_pkg::space_t s, input logic [15:0] a,
                     input logic [7:0] wd, input logic [7:0] x);
    @(posedge ref_clk_i) req_i <= '{1'b1, w, s, a, wd};
    if (!w) exp_q.push_back(x);
  endtask
  task automatic print_verdict;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Sampled mid-cycle, after the answer has settled
  always @(negedge ref_clk_i) if (rsp_o.valid === 1'b1) begin
    e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
    checked++;
    if (rsp_o.rdata !== e) begin
      err_total++;
      $display("ERROR rdata expected %h seen %h", e, rsp_o.rdata);
    end
  end
  initial begin
    #300000;
    err_total++;
    $display("ERROR watchdog expected done seen timeout");
    print_verdict;
  end
  initial begin
    req_i = '0;
    page_select_i = 8'h00;
    resetn_i = 1'b0;
    void'($urandom(81));
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    d0 = 8'($urandom);
    d = 8'($urandom);
    acc(1, sr, 16'h0000, d0, 0);
    acc(0, sr, 16'h0000, 0, d0);
    acc(1, sr, 16'h03FF, d, 0);
    acc(0, sr, 16'h03FF, 0, d);
    $display("ram test done");
    acc(1, sr, 16'h0400, ~d0, 0);
    acc(0, sr, 16'h0EFF, 0, 8'h00);
    acc(0, sr, 16'h8000, 0, d0);
    acc(0, sr, 16'h0F00, 0, 8'hA5);
    acc(1, sr, 16'h0F00, d, 0);
    acc(0, sr, 16'h0FFF, 0, 8'h5A);
    $display("register file test done");
    acc(0, sp, 16'h1000, 0, 8'hFF);
    acc(1, sp, 16'h1000, d, 0);
    acc(1, sp, 16'h0800, d, 0);
    acc(0, sp, 16'hFFFF, 0, 8'hFF);
    acc(1, sd, 16'h0010, d, 0);
    acc(0, sd, 16'h0010, 0, 8'h00);
    // Page changes alongside a data read, which ignores the overlay
    page_select_i <= {1'b1, 7'($urandom)};
    $display("program test done");
    for (int i = 0; i < 24; i++) acc(0, sp, 16'hFE3E + 16'(i), 0, (i >= 2 && i < 14) ? id[i-2] : 8'h00);
    acc(1, sp, 16'hFE40, 8'h00, 0);
    acc(0, sp, 16'hFE40, 0, 8'h45);
    acc(0, sp, 16'hFE00, 0, 8'h00);
    acc(0, sd, 16'h0000, 0, 8'h00);
    page_select_i <= 8'h7F;
    acc(0, sp, 16'hFE40, 0, 8'hFF);
    @(posedge ref_clk_i) req_i.valid <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    $display("overlay test done");
    if (exp_q.size() != 0) begin
      err_total++;
      $display("ERROR pending expected 0 seen %0d", exp_q.size());
    end
    print_verdict;
  end
endmodule
bind addr_space_decoder addr_space_chk #(.FLASH_BYTES(FLASH_BYTES)) i_addr_space_chk (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .req_i(req_i), .page_select_i(page_select_i), .rsp_o(rsp_o), .ctrl_rd_o(ctrl_rd_o),
  .ctrl_wr_o(ctrl_wr_o), .ctrl_rdata_i(ctrl_rdata_i), .flash_wr_o(flash_wr_o), .flash_addr_o(flash_addr_o),
  .flash_wdata_o(flash_wdata_o), .ctrl_addr_o(ctrl_addr_o), .ctrl_wdata_o(ctrl_wdata_o));
